/* File: pmbcd_pkg.sv */
`default_nettype none
package pmbcd_pkg;
   // ------------------------------------------------
   // command codes
   // ------------------------------------------------
   localparam logic [7:0] C_PAGE = 8'h00;
   localparam logic [7:0] C_OPER = 8'h01;
   localparam logic [7:0] C_ONOFF = 8'h02;
   localparam logic [7:0] C_CLR = 8'h03;
   localparam logic [7:0] C_PPWR = 8'h05;
   localparam logic [7:0] C_PPRD = 8'h06;
   localparam logic [7:0] C_PROT = 8'h10;
   localparam logic [7:0] C_STORE = 8'h15;
   localparam logic [7:0] C_RESTORE = 8'h16;
   localparam logic [7:0] C_SUMM = 8'h19;
   localparam logic [7:0] C_FMT = 8'h20;
   localparam logic [7:0] C_SETPT = 8'h21;
   localparam logic [7:0] C_CEIL = 8'h24;
   localparam logic [7:0] C_MUP = 8'h25;
   localparam logic [7:0] C_MDN = 8'h26;
   localparam logic [7:0] C_RSVD_LO = 8'hd0;
   localparam logic [7:0] PAGE_ALL = 8'hff;
   localparam logic [7:0] NUM_PAGES = 8'h02;
   // ------------------------------------------------
   // values after reset, constant answers
   // ------------------------------------------------
   localparam logic [7:0] RST_PAGE = 8'h00;
   localparam logic [7:0] RST_OPER = 8'h80;
   localparam logic [7:0] RST_ONOFF = 8'h1e;
   localparam logic [7:0] RST_PROT = 8'h00;
   localparam logic [7:0] SUMM_VAL = 8'hb0;
   localparam logic [7:0] FMT_VAL = 8'h14;
   localparam logic [15:0] RST_SETPT = 16'h1000;
   localparam logic [15:0] RST_CEIL = 16'h2c00;
   localparam logic [15:0] RST_MUP = 16'h10cd;
   localparam logic [15:0] RST_MDN = 16'h0f33;
   // ------------------------------------------------
   // timing
   // ------------------------------------------------
   localparam int CLK_HZ = 10_000_000;
   localparam int TMO_MS = 35;
   localparam int TMO_CYC = TMO_MS * (CLK_HZ / 1000);
   localparam int NVM_CYC = 16;
   // ------------------------------------------------
   // types
   // ------------------------------------------------
   typedef struct packed {
      logic [7:0] oper;
      logic [7:0] onoff;
      logic [15:0] setpt;
      logic [15:0] ceil;
      logic [15:0] mup;
      logic [15:0] mdn;
   } pmbcd_chan_t;
   localparam pmbcd_chan_t RST_CHAN = '{RST_OPER, RST_ONOFF,
      RST_SETPT, RST_CEIL, RST_MUP, RST_MDN};
   typedef struct packed {
      logic rd;
      logic ovf;
      logic [2:0] n;
      logic [7:0] cmd;
      logic [4:0][7:0] d;
   } pmbcd_txn_t;
   typedef struct packed {
      logic ok;
      logic [1:0] len;
      logic [15:0] word;
   } pmbcd_rsp_t;
   typedef struct packed {
      logic unsup;
      logic rsvd;
      logic busy;
      logic tmo;
   } pmbcd_fault_t;
   typedef struct packed {
      logic ok;
      logic paged;
      logic ro;
      logic [1:0] nb;
   } pmbcd_info_t;
   typedef enum logic [1:0] {
      ST_IDLE = 2'b01,
      ST_NVM = 2'b10
   } pmbcd_state_t;
endpackage : pmbcd_pkg
`default_nettype wire

/* File: pmbcd_decoder.sv */
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - undefined codes 0xd0..0xff are reserved and flagged.
// - undefined codes 0x00..0xcf are unsupported and flagged.
// - access to unsupported or reserved code records a communication fault.
// - output voltages use fixed exponent 2^-12, format byte 0x14.
// - packets arriving before previous is processed are refused as busy.
// - code 0x00 is non-paged read/write page select, resets 0x00.
// - code 0x01 paged read/write operating mode, default 0x80.
// - code 0x02 paged read/write on/off source config, default 0x1e.
// - send-byte 0x03 clears every set fault bit.
// - block write 0x05 applies embedded command to named page, page unchanged.
// - block process call 0x06 returns embedded command result from named page.
// - code 0x10 non-paged read/write protection level, default 0x00.
// - send-byte 0x15 copies operating settings into nonvolatile store.
// - send-byte 0x16 reloads operating settings from nonvolatile store.
// - code 0x19 read-only, always returns 0xb0.
// - code 0x20 paged read-only, returns 0x14.
// - code 0x21 paged read/write setpoint word, default 0x1000.
// - code 0x24 paged read/write ceiling word, default 0x2c00.
// - code 0x25 upper margin word, default 0x10cd; host keeps above nominal.
// - code 0x26 lower margin word, default 0x0f33; host keeps below nominal.
// - every write and block process call except a word block write 0x05 accepts an optional trailing check byte; plain reads refuse one; group packets work.
// - packet unfinished 35 ms after start is discarded and bus released.
module pmbcd_decoder #(
   parameter int TMO_CYCLES = pmbcd_pkg::TMO_CYC,
   parameter int NVM_CYCLES = pmbcd_pkg::NVM_CYC
) (
   // core clock and reset
   input wire logic core_clk,
   input wire logic rst,
   // framed packet bytes, serial clock domain
   input wire logic link_clk,
   input wire logic lk_start,
   input wire logic lk_byte_vld,
   input wire logic [7:0] lk_byte,
   input wire logic lk_stop,
   input wire logic lk_rd_req,
   // read answer and busy, serial clock domain
   output pmbcd_pkg::pmbcd_rsp_t lk_rsp,
   output logic lk_rsp_vld,
   output logic lk_busy,
   // settings and status, core domain
   output pmbcd_pkg::pmbcd_chan_t [1:0] chan_cfg,
   output logic [7:0] page_sel,
   output logic [7:0] protect_lvl,
   output pmbcd_pkg::pmbcd_fault_t fault,
   output logic bus_release,
   output logic nvm_busy
);
   import pmbcd_pkg::*;

   localparam int TW = $clog2(TMO_CYCLES + 1);
   localparam int NW = $clog2(NVM_CYCLES + 1);
   localparam int NVM_WAIT_MAX = NVM_CYCLES + 3;

   // ------------------------------------------------
   // serial clock side: packet assembly
   // ------------------------------------------------
   logic lrst_s1_r, lrst_r;
   logic ack_s1_r, ack_s2_r, ack_seen_r;
   logic post_tog_r, start_tog_r, busy_tog_r;
   logic busy_r, rsp_vld_r;
   logic got_cmd_r;
   pmbcd_txn_t bld_r, txn_r;
   pmbcd_rsp_t rsp_out_r;
   logic ack_tog_r;
   pmbcd_rsp_t rsp_r;

   wire logic pend = post_tog_r != ack_s2_r;
   wire logic pkt_end = lk_stop | lk_rd_req;
   wire logic ack_ev = ack_s2_r != ack_seen_r;
   wire logic bld_full = bld_r.n == 3'd5;

   // reset reaches this domain late; the link idles meanwhile
   always_ff @(posedge link_clk) begin
      lrst_s1_r <= rst;
      lrst_r <= lrst_s1_r;
      ack_s1_r <= ack_tog_r;
      ack_s2_r <= ack_s1_r;
   end

   always_ff @(posedge link_clk) begin
      if (lrst_r || lk_start) begin
         bld_r <= '0;
         got_cmd_r <= 1'b0;
      end else if (lk_byte_vld && !got_cmd_r) begin
         bld_r.cmd <= lk_byte;
         got_cmd_r <= 1'b1;
      end else if (lk_byte_vld && bld_full) begin
         bld_r.ovf <= 1'b1;
      end else if (lk_byte_vld) begin
         bld_r.d[bld_r.n] <= lk_byte;
         bld_r.n <= bld_r.n + 3'd1;
      end
   end

   // txn_r stays frozen while pending: the core reads it across domains
   always_ff @(posedge link_clk) begin
      if (lrst_r) begin
         txn_r <= '0;
         post_tog_r <= 1'b0;
         busy_tog_r <= 1'b0;
         busy_r <= 1'b0;
      end else if (pkt_end && got_cmd_r && pend) begin
         busy_tog_r <= ~busy_tog_r;
         busy_r <= 1'b1;
      end else if (pkt_end && got_cmd_r) begin
         txn_r <= bld_r;
         txn_r.rd <= lk_rd_req;
         post_tog_r <= ~post_tog_r;
      end else if (lk_start) begin
         busy_r <= 1'b0;
      end
   end

   always_ff @(posedge link_clk) begin
      if (lrst_r) begin
         start_tog_r <= 1'b0;
         ack_seen_r <= 1'b0;
         rsp_out_r <= '0;
         rsp_vld_r <= 1'b0;
      end else begin
         if (lk_start) start_tog_r <= ~start_tog_r;
         ack_seen_r <= ack_s2_r;
         if (ack_ev && txn_r.rd) begin
            rsp_out_r <= rsp_r;
            rsp_vld_r <= 1'b1;
         end else if (lk_start) begin
            rsp_vld_r <= 1'b0;
         end
      end
   end

   assign lk_rsp = rsp_out_r;
   assign lk_rsp_vld = rsp_vld_r;
   assign lk_busy = busy_r;

   a_busy_refuse: assert property (@(posedge link_clk) disable iff (lrst_r)
      pkt_end && got_cmd_r && pend |=> busy_r && $stable(post_tog_r))
      else $error("busy packet was not refused");

   // ------------------------------------------------
   // core side: event crossing and bus timer
   // ------------------------------------------------
   logic [2:0] ev_s1_r, ev_s2_r, ev_seen_r;
   wire logic [2:0] ev = ev_s2_r ^ ev_seen_r;
   wire logic post_ev = ev[0];
   wire logic start_ev = ev[1];
   wire logic busy_ev = ev[2];

   always_ff @(posedge core_clk) begin
      ev_s1_r <= {busy_tog_r, start_tog_r, post_tog_r};
      ev_s2_r <= ev_s1_r;
   end

   pmbcd_state_t st_r, st_nxt;
   logic [NW-1:0] nvm_cnt_r;
   logic [TW-1:0] tmr_r;
   logic run_r, expired_r, rel_r;
   wire logic tmo_hit = run_r && tmr_r == TW'(TMO_CYCLES - 1);
   wire logic proc = post_ev && st_r == ST_IDLE;

   always_ff @(posedge core_clk) begin
      if (rst) begin
         tmr_r <= '0;
         run_r <= 1'b0;
         expired_r <= 1'b0;
         rel_r <= 1'b0;
      end else if (start_ev) begin
         tmr_r <= '0;
         run_r <= 1'b1;
         expired_r <= 1'b0;
         rel_r <= 1'b0;
      end else if (tmo_hit) begin
         run_r <= 1'b0;
         expired_r <= 1'b1;
         rel_r <= 1'b1;
      end else if (proc || busy_ev) begin
         run_r <= 1'b0;
      end else if (run_r) begin
         tmr_r <= tmr_r + TW'(1);
      end
   end

   // ------------------------------------------------
   // command decode
   // ------------------------------------------------
   function automatic pmbcd_info_t cmd_info(input logic [7:0] c);
      pmbcd_info_t i;
      i = '{1'b1, 1'b0, 1'b0, 2'd1};
      case (c)
         C_PAGE, C_PROT: i.nb = 2'd1;
         C_OPER, C_ONOFF: i.paged = 1'b1;
         C_CLR, C_STORE, C_RESTORE: i.nb = 2'd0;
         C_SUMM: i.ro = 1'b1;
         C_FMT: i = '{1'b1, 1'b1, 1'b1, 2'd1};
         C_SETPT, C_CEIL, C_MUP, C_MDN: i = '{1'b1, 1'b1, 1'b0, 2'd2};
         default: i = '0;
      endcase
      return i;
   endfunction : cmd_info

   wire logic blk_wr = txn_r.cmd == C_PPWR;
   wire logic blk_rd = txn_r.cmd == C_PPRD;
   wire logic emb = blk_wr | blk_rd;
   wire logic [2:0] base = emb ? 3'd3 : 3'd0;
   wire logic [2:0] pl_n = txn_r.n - base;
   wire logic [7:0] e_cmd = emb ? txn_r.d[2] : txn_r.cmd;
   wire logic [7:0] e_page = emb ? txn_r.d[1] : page_sel;
   wire logic [7:0] d_lo = txn_r.d[base];
   wire logic [7:0] d_hi = txn_r.d[base + 3'd1];
   wire logic [15:0] wd = {d_hi, d_lo};
   wire pmbcd_info_t info = cmd_info(e_cmd);
   wire logic [7:0] n8 = {5'h00, txn_r.n};
   // block byte count may or may not include a trailing check byte
   wire logic hdr_ok = !emb || (txn_r.n >= 3'd3 &&
      (txn_r.d[0] == n8 - 8'd1 || txn_r.d[0] == n8 - 8'd2));
   wire logic nest_bad = emb && (e_cmd == C_PAGE || e_cmd == C_PPWR
      || e_cmd == C_PPRD);
   wire logic pg_ok = !info.paged || e_page == PAGE_ALL
      || e_page < NUM_PAGES;
   wire logic [2:0] nb3 = {1'b0, info.nb};
   wire logic len_ok = pl_n == nb3 || pl_n == nb3 + 3'd1;
   wire logic wr_ok = !txn_r.rd && info.ok && !info.ro && hdr_ok
      && !nest_bad && pg_ok && !txn_r.ovf && !blk_rd && len_ok;
   wire logic rd_ok = txn_r.rd && info.ok && info.nb != 2'd0 && pg_ok
      && !nest_bad && (emb ? blk_rd && hdr_ok : txn_r.n == 3'd0);
   wire logic act = proc && !expired_r;
   wire logic bad = act && !(txn_r.rd ? rd_ok : wr_ok);
   wire logic wr_go = act && wr_ok;
   wire logic rd_go = act && rd_ok;
   wire logic clr_go = wr_go && e_cmd == C_CLR;
   wire logic store_go = wr_go && e_cmd == C_STORE;
   wire logic restore_go = wr_go && e_cmd == C_RESTORE;
   wire logic rsvd_hit = e_cmd >= C_RSVD_LO;

   // ------------------------------------------------
   // settings and nonvolatile shadow
   // ------------------------------------------------
   pmbcd_chan_t [1:0] chan_r, chan_nxt, shad_r;
   logic [7:0] page_r, prot_r, shad_prot_r;
   wire logic rd_ch = e_page == PAGE_ALL ? 1'b0 : e_page[0];
   wire pmbcd_chan_t rc = chan_r[rd_ch];

   always_comb begin
      chan_nxt = chan_r;
      if (restore_go) begin
         chan_nxt = shad_r;
      end else if (wr_go && info.paged) begin
         for (int i = 0; i < 2; i++) begin
            if (e_page == PAGE_ALL || e_page[0] == i[0]) begin
               case (e_cmd)
                  C_OPER: chan_nxt[i].oper = d_lo;
                  C_ONOFF: chan_nxt[i].onoff = d_lo;
                  C_SETPT: chan_nxt[i].setpt = wd;
                  C_CEIL: chan_nxt[i].ceil = wd;
                  // margin ordering against nominal is the host's duty
                  C_MUP: chan_nxt[i].mup = wd;
                  C_MDN: chan_nxt[i].mdn = wd;
                  default: chan_nxt[i] = chan_r[i];
               endcase
            end
         end
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         chan_r <= {RST_CHAN, RST_CHAN};
         shad_r <= {RST_CHAN, RST_CHAN};
         page_r <= RST_PAGE;
         prot_r <= RST_PROT;
         shad_prot_r <= RST_PROT;
      end else begin
         chan_r <= chan_nxt;
         if (wr_go && !emb && e_cmd == C_PAGE) page_r <= d_lo;
         if (wr_go && e_cmd == C_PROT) prot_r <= d_lo;
         if (restore_go) prot_r <= shad_prot_r;
         if (store_go) begin
            shad_r <= chan_r;
            shad_prot_r <= prot_r;
         end
      end
   end

   // ------------------------------------------------
   // read answer
   // ------------------------------------------------
   logic [15:0] rword;
   always_comb begin
      case (e_cmd)
         C_OPER: rword = {8'h00, rc.oper};
         C_ONOFF: rword = {8'h00, rc.onoff};
         C_PROT: rword = {8'h00, prot_r};
         C_SUMM: rword = {8'h00, SUMM_VAL};
         C_FMT: rword = {8'h00, FMT_VAL};
         C_SETPT: rword = rc.setpt;
         C_CEIL: rword = rc.ceil;
         C_MUP: rword = rc.mup;
         C_MDN: rword = rc.mdn;
         default: rword = {8'h00, page_r};
      endcase
   end

   // ------------------------------------------------
   // faults, sequencing, acknowledge
   // ------------------------------------------------
   pmbcd_fault_t flt_r, flt_set;
   assign flt_set = '{bad && !rsvd_hit, bad && rsvd_hit, busy_ev, tmo_hit};

   always_ff @(posedge core_clk) begin
      if (rst) begin
         flt_r <= '0;
      end else if (clr_go) begin
         flt_r <= flt_set;
      end else begin
         flt_r <= flt_r | flt_set;
      end
   end

   wire logic nvm_go = store_go | restore_go;
   wire logic nvm_done = st_r == ST_NVM && nvm_cnt_r == NW'(NVM_CYCLES - 1);

   always_comb begin
      case (st_r)
         ST_IDLE: st_nxt = nvm_go ? ST_NVM : ST_IDLE;
         ST_NVM: st_nxt = nvm_done ? ST_IDLE : ST_NVM;
         default: st_nxt = ST_IDLE;
      endcase
   end

   // the acknowledge is held back through the nonvolatile copy,
   // so a packet sent meanwhile is refused as busy
   always_ff @(posedge core_clk) begin
      if (rst) begin
         st_r <= ST_IDLE;
         nvm_cnt_r <= '0;
         ack_tog_r <= 1'b0;
         rsp_r <= '0;
         ev_seen_r <= 3'b000;
      end else begin
         st_r <= st_nxt;
         nvm_cnt_r <= st_r == ST_NVM ? nvm_cnt_r + NW'(1) : '0;
         ev_seen_r[2:1] <= ev_s2_r[2:1];
         if (proc) ev_seen_r[0] <= ev_s2_r[0];
         if ((proc && !nvm_go) || nvm_done) ack_tog_r <= ~ack_tog_r;
         if (proc) rsp_r <= '{rd_go, rd_go ? info.nb : 2'd0, rword};
      end
   end

   assign chan_cfg = chan_r;
   assign page_sel = page_r;
   assign protect_lvl = prot_r;
   assign fault = flt_r;
   assign bus_release = rel_r;
   assign nvm_busy = st_r[1]; // one-hot bit of the copy state

   // ------------------------------------------------
   // checks
   // ------------------------------------------------
   sequence s_rst_rel;
      rst ##1 !rst;
   endsequence
   sequence s_store;
      store_go ##1 nvm_busy;
   endsequence

   a_reserved_flag: assert property (@(posedge core_clk) disable iff (rst)
      act && rsvd_hit && !clr_go |=> flt_r.rsvd)
      else $error("reserved code not flagged");
   a_unsup_flag: assert property (@(posedge core_clk) disable iff (rst)
      act && !info.ok && !rsvd_hit |=> flt_r.unsup && !$past(wr_go))
      else $error("unsupported code not flagged");
   a_format_read: assert property (@(posedge core_clk) disable iff (rst)
      rd_go && e_cmd == C_FMT |=> rsp_r.word == 16'h0014 && rsp_r.len == 2'd1)
      else $error("format byte wrong");
   a_summary_read: assert property (@(posedge core_clk) disable iff (rst)
      rd_go && e_cmd == C_SUMM |=> rsp_r.word[7:0] == 8'hb0)
      else $error("summary byte wrong");
   a_busy_fault: assert property (@(posedge core_clk) disable iff (rst)
      busy_ev && !clr_go |=> flt_r.busy)
      else $error("busy not recorded");
   a_reset_values: assert property (@(posedge core_clk)
      s_rst_rel |-> page_r == 8'h00 && chan_r[1].oper == 8'h80
         && chan_r[0].mdn == 16'h0f33 && prot_r == 8'h00)
      else $error("reset value wrong");
   a_clear_all: assert property (@(posedge core_clk) disable iff (rst)
      clr_go && flt_set == '0 |=> flt_r == '0)
      else $error("faults not cleared");
   a_nvm_hold: assert property (@(posedge core_clk) disable iff (rst)
      s_store |-> nvm_busy[*3] ##[1:NVM_WAIT_MAX] !nvm_busy)
      else $error("store busy window wrong");
   a_restore_copy: assert property (@(posedge core_clk) disable iff (rst)
      restore_go |=> chan_r == $past(shad_r))
      else $error("restore did not reload");
   a_paged_write: assert property (@(posedge core_clk) disable iff (rst)
      wr_go && e_cmd == C_SETPT && e_page == 8'h00 |=>
         chan_r[0].setpt == $past(wd) && $stable(chan_r[1]))
      else $error("paged write hit wrong channel");
   a_embed_page: assert property (@(posedge core_clk) disable iff (rst)
      wr_go && blk_wr |=> $stable(page_r))
      else $error("embedded write moved page");
   a_timeout_drop: assert property (@(posedge core_clk) disable iff (rst)
      proc && expired_r |=> $stable(chan_r) && $stable(page_r) && bus_release)
      else $error("late packet not discarded");
endmodule : pmbcd_decoder
`default_nettype wire

/* File: pmbcd_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
module pmbcd_host_model (
   // link clock control
   input wire logic link_clk,
   output logic clk_run,
   // packet framing
   output logic lk_start,
   output logic lk_byte_vld,
   output logic [7:0] lk_byte,
   output logic lk_stop,
   output logic lk_rd_req,
   // answer
   input wire logic lk_rsp_vld
);
   import pmbcd_pkg::*;
   initial begin
      clk_run = 1'b1;
      {lk_start, lk_byte_vld, lk_stop, lk_rd_req} = 4'h0;
      lk_byte = 8'h00;
   end
   task automatic tick();
      @(negedge link_clk);
   endtask : tick
   // ------------------------------------------------
   // one packet: n bytes, first byte in bits 7:0
   // ------------------------------------------------
   task automatic pkt(input int n, input logic [55:0] b, input bit rd, input int stall_ns,
                      input int tail);
      int i;
      // a zero tail leaves the clock running for a packet that follows at once
      if (clk_run !== 1'b1) clk_run = 1'b1;
      repeat (2) tick();
      lk_start = 1'b1;
      tick();
      lk_start = 1'b0;
      for (i = 0; i < n; i++) begin
         lk_byte_vld = 1'b1;
         lk_byte = b[8*i +: 8];
         tick();
      end
      lk_byte_vld = 1'b0;
      // idle lane flips so a stale byte never passes for a held one
      lk_byte = ~lk_byte;
      if (stall_ns > 0) begin
         #(stall_ns);
         tick();
      end
      // closed promptly unless a stall is asked for
      if (rd) begin
         lk_rd_req = 1'b1;
      end else begin
         lk_stop = 1'b1;
      end
      tick();
      {lk_stop, lk_rd_req} = 2'b00;
      for (i = 0; rd && lk_rsp_vld !== 1'b1 && i < 400; i++) tick();
      repeat (tail) tick();
      // serial clock stands still between packets unless the tail is zero
      if (tail > 0) clk_run = 1'b0;
   endtask : pkt
endmodule : pmbcd_host_model
`default_nettype wire

/* File: tb_pmbcd_decoder.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_pmbcd_decoder;
   import pmbcd_pkg::*;
   logic core_clk = 1'b0;
   logic rst = 1'b1;
   logic link_clk = 1'b0;
   logic clk_run, lk_start, lk_byte_vld, lk_stop, lk_rd_req, lk_rsp_vld, lk_busy;
   logic [7:0] lk_byte, page_sel, protect_lvl;
   logic bus_release, nvm_busy;
   pmbcd_rsp_t lk_rsp;
   pmbcd_chan_t [1:0] chan_cfg;
   pmbcd_fault_t fault;
   int errors = 0;
   int checks = 0;
   int cyc = 0;
   always #50 core_clk = ~core_clk;
   // offset keeps serial edges off the core edges
   initial begin
      #1.7;
      forever #3 link_clk = clk_run ? ~link_clk : 1'b0;
   end
   pmbcd_decoder #(.TMO_CYCLES(200), .NVM_CYCLES(16)) dut (
      .core_clk, .rst, .link_clk, .lk_start, .lk_byte_vld, .lk_byte, .lk_stop, .lk_rd_req,
      .lk_rsp, .lk_rsp_vld, .lk_busy, .chan_cfg, .page_sel, .protect_lvl, .fault,
      .bus_release, .nvm_busy);
   pmbcd_host_model host (
      .link_clk, .clk_run, .lk_start, .lk_byte_vld, .lk_byte, .lk_stop, .lk_rd_req,
      .lk_rsp_vld);
   // ------------------------------------------------
   // helpers
   // ------------------------------------------------
   task automatic end_sim();
      $display("errors %0d checks %0d", errors, checks);
      if (errors == 0 && checks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : end_sim
   task automatic chk(input string nm, input logic [79:0] seen, input logic [79:0] exp);
      checks++;
      if (seen !== exp) begin
         errors++;
         $display("unexpected %s: expected %h seen %h", nm, exp, seen);
      end
   endtask : chk
   task automatic cwait(input int k);
      repeat (k) @(negedge core_clk);
   endtask : cwait
   task automatic wr(input int n, input logic [55:0] b);
      host.pkt(n, b, 1'b0, 0, 8);
      cwait(6);
   endtask : wr
   // refused answers carry no word, so only ok and length are compared
   task automatic rd(input int n, input logic [55:0] b, input logic [18:0] exp);
      host.pkt(n, b, 1'b1, 0, 8);
      chk("answer valid", 80'(lk_rsp_vld), 80'h1);
      chk("read answer", 80'(exp[18] ? lk_rsp : {lk_rsp[18:16], 16'h0000}), 80'(exp));
   endtask : rd
   always @(posedge core_clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         errors++;
         end_sim();
      end
   end
   // ------------------------------------------------
   // main sequence
   // ------------------------------------------------
   initial begin
      static logic [7:0] dc [10] = '{C_PAGE, C_OPER, C_ONOFF, C_PROT, C_SUMM, C_FMT,
                                     C_SETPT, C_CEIL, C_MUP, C_MDN};
      static logic [15:0] dv [10] = '{16'(RST_PAGE), 16'(RST_OPER), 16'(RST_ONOFF),
                                      16'(RST_PROT), 16'(SUMM_VAL), 16'(FMT_VAL), RST_SETPT,
                                      RST_CEIL, RST_MUP, RST_MDN};
      // margins kept above and below the new nominal value
      static logic [7:0] wc [7] = '{C_OPER, C_ONOFF, C_PROT, C_SETPT, C_CEIL, C_MUP, C_MDN};
      static logic [15:0] wv [7] = '{16'h0040, 16'h001f, 16'h0080, 16'h5678, 16'h6000,
                                     16'h5800, 16'h5000};
      int i;
      logic [18:0] ex;
      repeat (6) @(negedge core_clk);
      rst = 1'b0;
      cwait(4);
      for (i = 0; i < 10; i++) begin
         ex = {1'b1, dc[i] >= C_SETPT ? 2'd2 : 2'd1, dv[i]};
         rd(1, 56'(dc[i]), ex);
      end
      chk("chan 1 after reset", 80'(chan_cfg[1]), 80'(RST_CHAN));
      chk("faults after reset", 80'(fault), 80'h0);
      wr(2, 56'h0100);
      for (i = 0; i < 7; i++) begin
         wr(wc[i] >= C_SETPT ? 3 : 2, {32'h0, wv[i], wc[i]});
      end
      for (i = 0; i < 7; i++) begin
         ex = {1'b1, wc[i] >= C_SETPT ? 2'd2 : 2'd1, wv[i]};
         rd(1, 56'(wc[i]), ex);
      end
      chk("chan 0 untouched", 80'(chan_cfg[0]), 80'(RST_CHAN));
      chk("protection level", 80'(protect_lvl), 80'h80);
      wr(2, 56'h0000);
      rd(1, 56'(C_OPER), {3'b101, 8'h00, RST_OPER});
      rd(1, 56'(C_PROT), 19'h50080);
      // refused accesses
      wr(2, {40'h0, 8'h55, C_SUMM});
      rd(1, 56'(C_SUMM), {3'b101, 8'h00, SUMM_VAL});
      chk("fault read-only", 80'(fault), 80'h8);
      rd(1, 56'h30, 19'h0);
      rd(1, 56'hd5, 19'h0);
      chk("fault unknown codes", 80'(fault), 80'hc);
      wr(1, 56'(C_CLR));
      chk("fault cleared", 80'(fault), 80'h0);
      // paged access by way of a named page
      wr(5, {16'h0, 8'h00, 8'h01, 8'h01, 8'h03, C_PPWR});
      chk("named page write", 80'(chan_cfg[1].oper), 80'h0);
      chk("page kept", 80'(page_sel), 80'h0);
      rd(4, {24'h0, 8'h01, 8'h01, 8'h02, C_PPRD}, 19'h50000);
      // trailing check byte, then store and restore
      wr(4, {24'h0, 8'ha5, 16'h4321, C_SETPT});
      chk("setpoint with check byte", 80'(chan_cfg[0].setpt), 80'h4321);
      wr(1, 56'(C_STORE));
      chk("store running", 80'(nvm_busy), 80'h1);
      for (i = 0; nvm_busy !== 1'b0 && i < 40; i++) cwait(1);
      wr(3, {32'h0, 16'h1111, C_SETPT});
      wr(1, 56'(C_RESTORE));
      for (i = 0; nvm_busy !== 1'b0 && i < 40; i++) cwait(1);
      chk("restored setpoint", 80'(chan_cfg[0].setpt), 80'h4321);
      chk("restored chan 1", 80'(chan_cfg[1].setpt), 80'h5678);
      // page 0xff reaches both channels at once
      wr(2, {40'h0, 8'hff, C_PAGE});
      wr(2, {40'h0, 8'h33, C_ONOFF});
      chk("all pages chan 0", 80'(chan_cfg[0].onoff), 80'h33);
      chk("all pages chan 1", 80'(chan_cfg[1].onoff), 80'h33);
      wr(2, {40'h0, 8'h00, C_PAGE});
      // second packet before the first is acknowledged
      host.pkt(3, {32'h0, 16'h2222, C_SETPT}, 1'b0, 0, 0);
      host.pkt(3, {32'h0, 16'h3333, C_SETPT}, 1'b0, 0, 8);
      cwait(6);
      chk("busy flag", 80'(lk_busy), 80'h1);
      chk("busy fault", 80'(fault.busy), 80'h1);
      chk("first packet kept", 80'(chan_cfg[0].setpt), 80'h2222);
      wr(1, 56'(C_CLR));
      // packet held open past the limit
      host.pkt(3, {32'h0, 16'h7777, C_SETPT}, 1'b0, 30000, 8);
      cwait(6);
      chk("bus released", 80'(bus_release), 80'h1);
      chk("timeout fault", 80'(fault.tmo), 80'h1);
      chk("late packet dropped", 80'(chan_cfg[0].setpt), 80'h2222);
      end_sim();
   end
endmodule : tb_pmbcd_decoder
`default_nettype wire
